// ---- hdl/spdc_target.v ----
// SPI target with standard 16-bit frames and daisy-chain frames.
// Assumes chip select, serial clock and serial input come from another domain
// and that the serial clock is at least eight times slower than sys_clk.
// The register store is internal; committed writes also leave on the write ports.
`timescale 1ns/1ps
`default_nettype none
`include "spdc_defs.vh"
module spdc_target #(
    parameter CNT_W = `SPDC_CNT_W
) (
    input wire sys_clk,
    input wire srst,
    input wire chip_select_n,
    input wire sclk,
    input wire sdi,
    output reg sdo,
    output wire sdo_oe,
    input wire supply_undervoltage_flag,
    input wire pump_undervoltage_flag,
    input wire overcurrent_flag,
    input wire stall_flag,
    input wire thermal_fault_flag,
    input wire open_load_flag,
    output reg clear_faults,
    output reg frame_error,
    output reg reg_write,
    output reg [`SPDC_ADDR_W-1:0] reg_write_addr,
    output reg [`SPDC_DATA_W-1:0] reg_write_data
);
    wire [2:0] pins_sync;
    wire cs_n_s;
    wire sclk_s;
    wire sdi_s;

    spdc_sync #(
        .WIDTH(3),
        .INIT(3'h4)
    ) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in({chip_select_n, sclk, sdi}),
        .sync_out(pins_sync)
    );

    assign cs_n_s = pins_sync[2];
    assign sclk_s = pins_sync[1];
    assign sdi_s = pins_sync[0];

    reg cs_n_prev;
    reg sclk_prev;
    wire cs_act = ~cs_n_s;
    wire cs_fall = cs_n_prev & ~cs_n_s;
    wire cs_rise = ~cs_n_prev & cs_n_s;
    // Edges count only inside a frame
    wire sclk_rise = cs_act & ~cs_n_prev & sclk_s & ~sclk_prev;
    wire sclk_fall = cs_act & ~cs_n_prev & ~sclk_s & sclk_prev;

    // Receive side
    reg [CNT_W-1:0] rx_cnt;
    reg [`SPDC_DATA_W-1:0] rx_shift;
    reg [`SPDC_DATA_W-1:0] fwd_byte;
    wire [`SPDC_DATA_W-1:0] rx_byte = {rx_shift[`SPDC_DATA_W-2:0], sdi_s};
    wire byte_done = sclk_fall && (rx_cnt[2:0] == `SPDC_BIT_LAST);
    wire [CNT_W-4:0] byte_idx = rx_cnt[CNT_W-1:3];

    // Frame decode state
    reg chain_mode;
    reg hdr_seen;
    reg [CNT_W-4:0] hdr_idx;
    reg [`SPDC_ADDR_W-1:0] position;
    reg [`SPDC_ADDR_W-1:0] chain_len;
    reg clear_req;
    reg cmd_seen;
    reg cmd_dir;
    reg [`SPDC_ADDR_W-1:0] cmd_addr;
    reg [`SPDC_DATA_W-1:0] cmd_data;
    reg rpt_pending;

    // Slot numbers of this device's address and data bytes in a chain frame
    wire [CNT_W-4:0] own_addr_idx = hdr_idx + 8'h02 + {2'b00, position};
    wire [CNT_W-4:0] own_data_idx = own_addr_idx + {2'b00, chain_len};
    wire [1:0] rx_mark = rx_byte[`SPDC_DATA_W-1:`SPDC_DATA_W-2];

    // Byte slots, compared on the falling edge that completes a byte
    wire slot_first = (byte_idx == {(CNT_W-3){1'b0}});
    wire slot_second = (byte_idx == {{(CNT_W-4){1'b0}}, 1'b1});
    wire slot_second_header_byte = (byte_idx == hdr_idx + 8'h01);
    wire slot_own_addr = (byte_idx == own_addr_idx);
    wire slot_own_data = (byte_idx == own_data_idx);
    wire own_report = chain_mode && hdr_seen && slot_own_addr;

    // Expected chain length in clocks: 16 + 16 * n
    wire [CNT_W-1:0] chain_bits = `SPDC_STD_FRAME_BITS + {1'b0, chain_len, 4'h0};
    wire count_ok = chain_mode ? (hdr_seen && (rx_cnt == chain_bits))
                               : (rx_cnt == `SPDC_STD_FRAME_BITS);

    wire [`SPDC_DATA_W-1:0] rd_data;

    spdc_regfile u_regs (
        .sys_clk(sys_clk),
        .srst(srst),
        .wr_en(reg_write),
        .wr_addr(reg_write_addr),
        .wr_data(reg_write_data),
        .rd_addr(cmd_addr),
        .rd_data(rd_data)
    );

    always @(posedge sys_clk) begin
        if (srst) begin
            cs_n_prev <= 1'b1;
        end else begin
            cs_n_prev <= cs_n_s;
        end
    end

    // Idle-low reset value, so reset release never shows a false edge
    always @(posedge sys_clk) begin
        if (srst) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= sclk_s;
        end
    end

    // Saturate so an overlong frame can never wrap back to valid
    always @(posedge sys_clk) begin
        if (srst || cs_fall) begin
            rx_cnt <= `SPDC_CNT_RESET;
        end else if (sclk_fall && rx_cnt != {CNT_W{1'b1}}) begin
            rx_cnt <= rx_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Frame decode: standard command, or chain position, headers and own slots
    always @(posedge sys_clk) begin
        if (srst || cs_fall) begin
            rx_shift <= `SPDC_BYTE_RESET;
            fwd_byte <= `SPDC_BYTE_RESET;
            chain_mode <= 1'b0;
            hdr_seen <= 1'b0;
            hdr_idx <= {(CNT_W-3){1'b0}};
            position <= `SPDC_POS_RESET;
            chain_len <= `SPDC_POS_RESET;
            clear_req <= 1'b0;
            cmd_seen <= 1'b0;
            cmd_dir <= 1'b1;
            cmd_addr <= `SPDC_POS_RESET;
            cmd_data <= `SPDC_BYTE_RESET;
        end else if (sclk_fall) begin
            rx_shift <= rx_byte;
            if (byte_done) begin
                fwd_byte <= rx_byte;
                if (slot_first) begin
                    chain_mode <= rx_byte[`SPDC_FRAME_TYPE_BIT];
                end
                if (slot_first && !rx_byte[`SPDC_FRAME_TYPE_BIT]) begin
                    cmd_seen <= 1'b1;
                    cmd_dir <= rx_byte[`SPDC_DIR_BIT];
                    cmd_addr <= rx_byte[`SPDC_ADDR_W-1:0];
                end else if (!chain_mode && !slot_first) begin
                    if (slot_second) begin
                        cmd_data <= rx_byte;
                    end
                end else if (!hdr_seen) begin
                    // Count upstream status bytes until the first header
                    if (rx_mark == `SPDC_MARK_STATUS) begin
                        position <= position + 6'h01;
                    end else if (rx_mark == `SPDC_MARK_HEADER) begin
                        hdr_seen <= 1'b1;
                        hdr_idx <= byte_idx;
                        chain_len <= rx_byte[`SPDC_ADDR_W-1:0];
                    end
                end else if (slot_second_header_byte) begin
                    clear_req <= rx_byte[`SPDC_CLEAR_BIT];
                end else if (slot_own_addr) begin
                    cmd_seen <= 1'b1;
                    cmd_dir <= rx_byte[`SPDC_DIR_BIT];
                    cmd_addr <= rx_byte[`SPDC_ADDR_W-1:0];
                end else if (slot_own_data) begin
                    cmd_data <= rx_byte;
                end
            end
        end
    end

    // End of frame: commit, flag errors, global clear
    always @(posedge sys_clk) begin
        if (srst) begin
            frame_error <= 1'b0;
            clear_faults <= 1'b0;
            reg_write <= 1'b0;
        end else begin
            frame_error <= cs_rise && !count_ok;
            clear_faults <= cs_rise && chain_mode && hdr_seen && clear_req;
            reg_write <= cs_rise && count_ok && cmd_seen
                         && (cmd_dir == `SPDC_DIR_WRITE);
        end
    end

    // Held until the next frame ends so a slow consumer can still read them
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_write_addr <= `SPDC_POS_RESET;
            reg_write_data <= `SPDC_BYTE_RESET;
        end else if (cs_rise) begin
            reg_write_addr <= cmd_addr;
            reg_write_data <= cmd_data;
        end
    end

    // Transmit side
    reg [CNT_W-1:0] tx_cnt;
    reg [`SPDC_DATA_W-2:0] tx_shift;
    reg [`SPDC_DATA_W-1:0] status_byte;
    reg [`SPDC_DATA_W-1:0] next_byte;
    wire [CNT_W-4:0] tx_idx = tx_cnt[CNT_W-1:3];
    wire tx_byte_start = sclk_rise && (tx_cnt[2:0] == `SPDC_BIT_FIRST);

    always @* begin
        if (tx_idx == {(CNT_W-3){1'b0}}) begin
            next_byte = status_byte;
        end else if (!chain_mode) begin
            next_byte = (tx_idx == {{(CNT_W-4){1'b0}}, 1'b1}) ? rd_data : fwd_byte;
        end else begin
            // One-byte delay line; own address slot becomes the report
            next_byte = rpt_pending ? rd_data : fwd_byte;
        end
    end

    // Fault flags frozen for the whole frame, so one frame reports one snapshot
    always @(posedge sys_clk) begin
        if (srst || cs_fall) begin
            status_byte <= {`SPDC_MARK_STATUS, supply_undervoltage_flag,
                            pump_undervoltage_flag, overcurrent_flag, stall_flag,
                            thermal_fault_flag, open_load_flag};
        end
    end

    always @(posedge sys_clk) begin
        if (srst || cs_fall) begin
            tx_cnt <= `SPDC_CNT_RESET;
        end else if (sclk_rise && tx_cnt != {CNT_W{1'b1}}) begin
            tx_cnt <= tx_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Set at this device's address slot, used by the next byte start
    always @(posedge sys_clk) begin
        if (srst || cs_fall) begin
            rpt_pending <= 1'b0;
        end else if (byte_done && own_report) begin
            rpt_pending <= 1'b1;
        end else if (tx_byte_start) begin
            rpt_pending <= 1'b0;
        end
    end

    // Line keeps its last bit between bytes; sdo_oe alone frees the pin
    always @(posedge sys_clk) begin
        if (srst || cs_fall) begin
            tx_shift <= 7'h00;
            sdo <= 1'b1;
        end else if (tx_byte_start) begin
            sdo <= next_byte[`SPDC_DATA_W-1];
            tx_shift <= next_byte[`SPDC_DATA_W-2:0];
        end else if (sclk_rise) begin
            sdo <= tx_shift[`SPDC_DATA_W-2];
            tx_shift <= {tx_shift[`SPDC_DATA_W-3:0], 1'b0};
        end
    end

    // Drive only inside a frame
    assign sdo_oe = cs_act & ~cs_n_prev;
endmodule
`default_nettype wire

// ---- hdl/spdc_defs.vh ----
// Constants shared by the daisy-chain SPI target files.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SPDC_DEFS_VH
`define SPDC_DEFS_VH

// Frame geometry
`define SPDC_BYTE_BITS      4'h8
`define SPDC_CNT_W          11
`define SPDC_STD_FRAME_BITS 11'h010
`define SPDC_BIT_LAST       3'h7
`define SPDC_BIT_FIRST      3'h0

// Marker pairs in the two most significant bits of a byte
`define SPDC_MARK_STATUS    2'h3
`define SPDC_MARK_HEADER    2'h2

// Command byte fields
`define SPDC_FRAME_TYPE_BIT 7
`define SPDC_DIR_BIT        6
`define SPDC_DIR_WRITE      1'h0
`define SPDC_ADDR_W         6

// Second header byte: clear-fault flag just below the marker pair
`define SPDC_CLEAR_BIT      5

// Register file
`define SPDC_DATA_W         8
`define SPDC_REG_RESET      8'h00

// Reset values
`define SPDC_CNT_RESET      11'h000
`define SPDC_BYTE_RESET     8'h00
`define SPDC_POS_RESET      6'h00

`endif

// ---- hdl/spdc_sync.v ----
// Two-stage synchroniser for a group of independent level signals.
// Assumes each bit is a slow level or a clock far slower than sys_clk.
`timescale 1ns/1ps
`default_nettype none
module spdc_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire srst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    // First stage read by the second stage only
    reg [WIDTH-1:0] meta;

    always @(posedge sys_clk) begin
        if (srst) begin
            meta <= INIT;
            sync_out <= INIT;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/spdc_regfile.v ----
// Register store addressed by the serial command: one write, one read port.
// Assumes read data is wanted one sys_clk after the address is presented.
`timescale 1ns/1ps
`default_nettype none
`include "spdc_defs.vh"
module spdc_regfile #(
    parameter AW = `SPDC_ADDR_W,
    parameter DW = `SPDC_DATA_W
) (
    input wire sys_clk,
    input wire srst,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer i;

    always @(posedge sys_clk) begin
        if (srst) begin
            for (i = 0; i < (1 << AW); i = i + 1) begin
                mem[i] <= `SPDC_REG_RESET;
            end
            rd_data <= `SPDC_REG_RESET;
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            // Old contents on a same-cycle write: report shows prior value
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ---- sim/spdc_target_props.sv ----
// Port checker for the daisy-chain SPI target, bound into every instance.
// Assumes sclk is at least eight sys_clk periods long and is held low at select edges.
`timescale 1ns/1ps
`default_nettype none
module spdc_target_props (
    input wire sys_clk,
    input wire srst,
    input wire chip_select_n,
    input wire sclk,
    input wire sdo,
    input wire sdo_oe,
    input wire clear_faults,
    input wire frame_error,
    input wire reg_write,
    input wire [5:0] reg_write_addr,
    input wire [7:0] reg_write_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    idle_undriven_a: assert property (chip_select_n [*5] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    select_drives_a: assert property (!chip_select_n [*5] |-> sdo_oe)
        else $error("sdo not driven while selected");
    // Half periods span four cycles, so two low samples follow any late update
    sdo_edge_a: assert property (sdo_oe && $past(sdo_oe) && !sclk && !$past(sclk) |-> $stable(sdo))
        else $error("sdo moved while sclk low");
    write_single_a: assert property (reg_write |=> !reg_write)
        else $error("write pulse longer than one cycle");
    write_on_rise_a: assert property (reg_write |-> chip_select_n && $past(chip_select_n, 3))
        else $error("write outside select rise");
    error_on_rise_a: assert property (frame_error |-> chip_select_n && $past(chip_select_n, 3) && !reg_write)
        else $error("frame error misplaced or with write");
    error_single_a: assert property (frame_error |=> !frame_error)
        else $error("frame error longer than one cycle");
    clear_on_rise_a: assert property (clear_faults |-> chip_select_n && $past(chip_select_n, 3))
        else $error("fault clear outside select rise");
    write_held_a: assert property (!chip_select_n |-> $stable(reg_write_addr) && $stable(reg_write_data))
        else $error("write address or data moved in frame");

    cover property (reg_write);
    cover property (frame_error);
    cover property (clear_faults);
endmodule

bind spdc_target spdc_target_props i_props (
    .sys_clk(sys_clk), .srst(srst), .chip_select_n(chip_select_n), .sclk(sclk),
    .sdo(sdo), .sdo_oe(sdo_oe), .clear_faults(clear_faults), .frame_error(frame_error),
    .reg_write(reg_write), .reg_write_addr(reg_write_addr), .reg_write_data(reg_write_data)
);
`default_nettype wire

// ---- sim/spdc_host.sv ----
// Model of the link controller that drives the SPI target.
// Assumes it is the only driver of select, serial clock and serial input.
`timescale 1ns/1ps
`default_nettype none
module spdc_host (
    input wire sys_clk,
    input wire sdo_line,
    output logic chip_select_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        chip_select_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // One bit is four cycles high, four low: an 800 ns link clock
    task automatic frame(input int nb, input logic [63:0] din, output logic [63:0] dout);
        int i;
        dout = 64'h0000_0000_0000_0000;
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (i = nb - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            sdi <= din[i];
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b0;
            repeat (4) @(posedge sys_clk);
            // Sampled late in the low phase, where the bit still stands
            dout[i] = sdo_line;
        end
        chip_select_n <= 1'b1;
        sdi <= ~sdi;
        repeat (10) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the daisy-chain SPI target.
// Assumes the host model drives the link and this bench drives the fault levels.
`timescale 1ns/1ps
`default_nettype none
`include "spdc_defs.vh"
module testbench;
    localparam logic [5:0] F1 = 6'h29;
    localparam logic [5:0] F2 = 6'h16;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] faults = 6'h00;
    logic [13:0] wr_seen = 14'h0000;
    wire chip_select_n, sclk, sdi, sdo, sdo_oe, clear_faults, frame_error, reg_write;
    wire [`SPDC_ADDR_W-1:0] reg_write_addr;
    wire [`SPDC_DATA_W-1:0] reg_write_data;
    // Undriven output reads as high impedance, so a missing bit cannot match
    wire sdo_line = sdo_oe ? sdo : 1'bz;
    int fails = 0;
    int samples_checked = 0;
    int n_wr = 0;
    int n_err = 0;
    int n_clr = 0;

    spdc_target i_dut (
        .sys_clk(sys_clk), .srst(srst), .chip_select_n(chip_select_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .supply_undervoltage_flag(faults[5]),
        .pump_undervoltage_flag(faults[4]), .overcurrent_flag(faults[3]),
        .stall_flag(faults[2]), .thermal_fault_flag(faults[1]), .open_load_flag(faults[0]),
        .clear_faults(clear_faults), .frame_error(frame_error), .reg_write(reg_write),
        .reg_write_addr(reg_write_addr), .reg_write_data(reg_write_data)
    );
    spdc_host i_host (
        .sys_clk(sys_clk), .sdo_line(sdo_line), .chip_select_n(chip_select_n),
        .sclk(sclk), .sdi(sdi)
    );

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (reg_write) begin
            n_wr <= n_wr + 1;
            wr_seen <= {reg_write_addr, reg_write_data};
        end
        if (frame_error) n_err <= n_err + 1;
        if (clear_faults) n_clr <= n_clr + 1;
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Status byte is built from the fault levels; tail is what follows it
    task automatic run(input int nb, input logic [5:0] f, input logic [63:0] din,
                       input logic [63:0] tail, input int dw, input int de, input int dc,
                       input logic [13:0] wv);
        logic [63:0] got;
        logic [63:0] exp;
        int w0;
        int e0;
        int c0;
        w0 = n_wr;
        e0 = n_err;
        c0 = n_clr;
        faults <= f;
        i_host.frame(nb, din, got);
        exp = ({2'b11, f, 56'h0} | (tail << (64 - nb))) >> (64 - nb);
        check("sdo stream", exp, got);
        check("write pulses", dw, n_wr - w0);
        check("frame errors", de, n_err - e0);
        check("clear pulses", dc, n_clr - c0);
        if (dw != 0) check("write address and data", wv, wr_seen);
    endtask

    task automatic conclude();
        if (fails == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        fails++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        run(16, F1, 16'h15A5, 8'h00, 1, 0, 0, {6'h15, 8'hA5});
        run(16, F2, 16'h55FF, 8'hA5, 0, 0, 0, 14'h0000);
        run(15, F1, 16'h153C >> 1, 8'hA5 >> 1, 0, 1, 0, 14'h0000);
        run(16, 6'h3F, 16'h2A5A, 8'h00, 1, 0, 0, {6'h2A, 8'h5A});
        run(16, 6'h00, 16'h153C, 8'hA5, 1, 0, 0, {6'h15, 8'h3C});
        run(32, F2, 32'h81AB_6A00, 24'h81_AB5A, 0, 0, 1, 14'h0000);
        run(32, F1, 32'h818B_1577, 24'h81_8B3C, 1, 0, 0, {6'h15, 8'h77});
        run(48, F2, 48'hC582_8B00_5500, 40'hC5_828B_0077, 0, 0, 0, 14'h0000);
        run(24, F1, 24'h81_8B15, 16'h818B, 0, 1, 0, 14'h0000);
        conclude();
    end
endmodule
`default_nettype wire
